// ### verilog/trg_params.svh
// Register offsets, reset values, masks and timing constants
`ifndef TRG_PARAMS_SVH
`define TRG_PARAMS_SVH
// ****************************************
// Register byte addresses
// ****************************************
`define TRG_OFF_GAP 20'h00410
`define TRG_OFF_THR 20'h00458
`define TRG_OFF_BLO 20'h03800
`define TRG_OFF_BHI 20'h03804
`define TRG_OFF_LEN 20'h03808
`define TRG_OFF_HEAD 20'h03810
`define TRG_OFF_TAIL 20'h03818
`define TRG_OFF_ARB 20'h03840
`define TRG_OFF_CTRL 20'h03880
`define TRG_OFF_STAT 20'h03884
`define TRG_ALS_BLO 20'h00420
`define TRG_ALS_BHI 20'h00424
`define TRG_ALS_LEN 20'h00428
`define TRG_ALS_HEAD 20'h00430
`define TRG_ALS_TAIL 20'h00438
// ****************************************
// Reset values and masks
// ****************************************
`define TRG_GAP_RST 32'h00602008
`define TRG_GAP_MASK 32'h3fffffff
`define TRG_BLO_MASK 32'hfffffff0
`define TRG_LEN_MASK 32'h000fff80
`define TRG_IDX_MASK 32'h0000ffff
`define TRG_ARB_RST 32'h00000403
`define TRG_ARB_MASK 32'h780007ff
`define TRG_CTRL_MASK 32'h00000007
// ****************************************
// Timing
// ****************************************
`define TRG_GAP_XING_CLKS 10'h006
`define TRG_DESC_BYTES_LOG2 4
`endif

// ### verilog/trg_pkg.sv
// Types for the transmit ring and gap control block
package trg_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PHASE1,
    ST_PHASE2,
    ST_READY
  } trg_gap_st_t;
endpackage : trg_pkg

// ### verilog/trg_tx_ring_gap.sv
// Transmit ring registers, gap timer and programmable throttle over APB
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "trg_params.svh"
// How it works
// [R1] b2b_gap_time spaces back-to-back frames
// [R2] Carrier sense restarts gap during phase one
// [R3] Carrier ignored after phase one ends
// [R4] gap_total_time is non-b2b total gap
// [R5] Phase fields only used in half duplex
// [R6] Gap waits six extra MAC clocks
// [R7] Throttle delays b2b hand-off, 8ns units
// [R8] Throttle applies to first attempt only
// [R9] B2b spacing is max of throttle, gap
// [R10] Base low bits 3:0 read zero
// [R11] Software aligns ring to 16 bytes
// [R12] Base address is high:low concatenated
// [R13] Length bits 6:0 read zero
// [R14] Software sets length multiple of 128
// [R15] Hardware advances 16-bit head index
// [R16] Software writes head only before enable
// [R17] Descriptors between head and tail sent
// [R18] Ring registers decoded at alias addresses
// [R19] Software keeps queue enable bit set
// [R20] Software never writes arbitration field zero
// [R21] Empty when head equals tail; head wraps
module trg_tx_ring_gap (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic carrier_sense,
  input wire logic frame_done,
  input wire logic frame_retry,
  output logic desc_valid,
  output logic [63:0] desc_addr,
  input wire logic desc_taken,
  output logic tx_start,
  input wire logic tx_ack
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [31:0] gap;
    logic [15:0] thr;
    logic [31:0] blo;
    logic [31:0] bhi;
    logic [31:0] len;
    logic [15:0] head;
    logic [15:0] tail;
    logic [31:0] arb;
    logic [2:0] ctrl;
    trg_pkg::trg_gap_st_t st;
    logic [15:0] cnt;
    logic b2b;
    logic retry;
    logic cs_s1;
    logic cs_s2;
    logic [31:0] rdata;
  } trg_state_t;

  trg_state_t s_q;
  trg_state_t s_d;

  logic wr;
  logic rd;
  logic hit;
  logic en;
  logic full_dup;
  logic [15:0] b2b_len;
  logic [15:0] tot_len;
  logic [15:0] ph1_len;
  logic [15:0] thr_len;
  logic [15:0] last_idx;
  logic empty;
  logic [31:0] rmux;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign en = s_q.ctrl[0];
  assign full_dup = s_q.ctrl[1];
  // [R21] Empty ring test
  assign empty = (s_q.head == s_q.tail);
  // [R21] Last descriptor fitting the length
  assign last_idx = 16'(s_q.len[31:`TRG_DESC_BYTES_LOG2]) - 16'h0001;
  // [R1] Back-to-back gap field
  // [R6] Crossing overhead on back-to-back and total gap fields
  assign b2b_len = {6'h00, s_q.gap[9:0]} + {6'h00, `TRG_GAP_XING_CLKS};
  assign tot_len = {6'h00, s_q.gap[29:20]} + {6'h00, `TRG_GAP_XING_CLKS};
  assign ph1_len = {6'h00, s_q.gap[19:10]};
  // [R8] Throttle ignored on retries
  assign thr_len = s_q.retry ? 16'h0000 : s_q.thr;

  // ****************************************
  // Register read decode
  // ****************************************
  always_comb begin
    hit = 1'b1;
    rmux = 32'h00000000;
    unique case (paddr)
      `TRG_OFF_GAP: rmux = s_q.gap;
      `TRG_OFF_THR: rmux = {16'h0000, s_q.thr};
      // [R18] Alias decode
      `TRG_OFF_BLO, `TRG_ALS_BLO: rmux = s_q.blo;
      `TRG_OFF_BHI, `TRG_ALS_BHI: rmux = s_q.bhi;
      `TRG_OFF_LEN, `TRG_ALS_LEN: rmux = s_q.len;
      `TRG_OFF_HEAD, `TRG_ALS_HEAD: rmux = {16'h0000, s_q.head};
      `TRG_OFF_TAIL, `TRG_ALS_TAIL: rmux = {16'h0000, s_q.tail};
      `TRG_OFF_ARB: rmux = s_q.arb;
      `TRG_OFF_CTRL: rmux = {29'h0, s_q.ctrl};
      `TRG_OFF_STAT: rmux = {28'h0000000, empty, 1'b0, 2'(s_q.st)};
      default: hit = 1'b0;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.cs_s1 = carrier_sense;
    s_d.cs_s2 = s_q.cs_s1;
    if (rd) begin
      s_d.rdata = rmux;
    end
    if (wr) begin
      unique case (paddr)
        `TRG_OFF_GAP: s_d.gap = pwdata & `TRG_GAP_MASK;
        // [R7] Throttle value in clocks
        `TRG_OFF_THR: s_d.thr = pwdata[15:0];
        // [R10] Low base bits dropped
        `TRG_OFF_BLO, `TRG_ALS_BLO: s_d.blo = pwdata & `TRG_BLO_MASK;
        `TRG_OFF_BHI, `TRG_ALS_BHI: s_d.bhi = pwdata;
        // [R13] Length low bits dropped
        `TRG_OFF_LEN, `TRG_ALS_LEN: s_d.len = pwdata & `TRG_LEN_MASK;
        `TRG_OFF_HEAD, `TRG_ALS_HEAD: s_d.head = pwdata[15:0];
        // [R17] Software advances tail
        `TRG_OFF_TAIL, `TRG_ALS_TAIL: s_d.tail = pwdata[15:0];
        `TRG_OFF_ARB: s_d.arb = pwdata & `TRG_ARB_MASK;
        `TRG_OFF_CTRL: s_d.ctrl = pwdata[2:0];
        default: s_d.ctrl = s_q.ctrl;
      endcase
    end
    // [R15] Head advances when descriptor taken
    if (desc_valid && desc_taken) begin
      // [R21] Wrap after last descriptor
      s_d.head = (s_q.head >= last_idx) ? 16'h0000 : s_q.head + 16'h0001;
    end
    if (frame_done) begin
      s_d.b2b = !empty;
      s_d.retry = frame_retry;
      s_d.cnt = 16'h0000;
      s_d.st = trg_pkg::ST_PHASE1;
    end else begin
      unique case (s_q.st)
        trg_pkg::ST_IDLE: begin
          s_d.st = trg_pkg::ST_READY;
        end
        trg_pkg::ST_PHASE1: begin
          s_d.cnt = s_q.cnt + 16'h0001;
          if (s_q.b2b) begin
            // [R9] Longer of throttle and gap
            if (s_q.cnt + 16'h0001 >= b2b_len &&
                s_q.cnt + 16'h0001 >= thr_len) begin
              s_d.st = trg_pkg::ST_READY;
            end
          // [R5] Full duplex uses back-to-back gap only
          end else if (full_dup) begin
            if (s_q.cnt + 16'h0001 >= b2b_len) begin
              s_d.st = trg_pkg::ST_READY;
            end
          // [R2] Carrier restarts the count
          end else if (s_q.cs_s2) begin
            s_d.cnt = 16'h0000;
          end else if (s_q.cnt + 16'h0001 >= ph1_len) begin
            s_d.st = trg_pkg::ST_PHASE2;
          end
        end
        trg_pkg::ST_PHASE2: begin
          // [R3] Carrier ignored here
          // [R4] Total includes phase one
          s_d.cnt = s_q.cnt + 16'h0001;
          if (s_q.cnt + 16'h0001 >= tot_len) begin
            s_d.st = trg_pkg::ST_READY;
          end
        end
        trg_pkg::ST_READY: begin
          s_d.st = trg_pkg::ST_READY;
        end
      endcase
    end
    if (!rst_n) begin
      s_d = '0;
      s_d.gap = `TRG_GAP_RST;
      s_d.arb = `TRG_ARB_RST;
    end
  end

  always_ff @(posedge core_clk) begin
    s_q <= s_d;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata = s_q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  // [R17] Offer descriptors between head and tail
  assign desc_valid = en && !empty;
  // [R12] Base high over low plus index
  assign desc_addr = {s_q.bhi, s_q.blo} +
                     {44'h00000000000, s_q.head, 4'h0};
  // Full duplex never asserts carrier in practice; tx_ack holds tx_start low
  assign tx_start = en && (s_q.st == trg_pkg::ST_READY) && !tx_ack;

  // ****************************************
  // Checks
  // ****************************************
  property p_lowbits; // [R10]
    @(posedge core_clk) disable iff (!rst_n)
    s_q.blo[3:0] == 4'h0 && s_q.len[6:0] == 7'h00;
  endproperty
  a_lowbits: assert property (p_lowbits) else $error("low bits set"); // [R13]

  property p_empty; // [R21]
    @(posedge core_clk) disable iff (!rst_n)
    (s_q.head == s_q.tail) |-> !desc_valid;
  endproperty
  a_empty: assert property (p_empty) else $error("valid when empty"); // [R21]

  property p_head; // [R15]
    @(posedge core_clk) disable iff (!rst_n)
    (desc_valid && desc_taken && !wr) |=> (s_q.head != $past(s_q.head));
  endproperty
  a_head: assert property (p_head) else $error("head stuck"); // [R15]

  property p_cs; // [R2]
    @(posedge core_clk) disable iff (!rst_n)
    (s_q.st == trg_pkg::ST_PHASE1 && !s_q.b2b && !full_dup && s_q.cs_s2 &&
     !frame_done) |=> s_q.cnt == 16'h0000;
  endproperty
  a_cs: assert property (p_cs) else $error("no restart"); // [R2]

  property p_b2b; // [R9]
    @(posedge core_clk) disable iff (!rst_n)
    ($rose(s_q.st == trg_pkg::ST_READY) && s_q.b2b) |->
      (s_q.cnt >= b2b_len && s_q.cnt >= thr_len);
  endproperty
  a_b2b: assert property (p_b2b) else $error("gap short"); // [R9]

  property p_ph2; // [R4]
    @(posedge core_clk) disable iff (!rst_n)
    (s_q.st == trg_pkg::ST_READY && $past(s_q.st) == trg_pkg::ST_PHASE2) |->
      s_q.cnt >= tot_len;
  endproperty
  a_ph2: assert property (p_ph2) else $error("total short"); // [R6]

  property p_alias; // [R18]
    @(posedge core_clk) disable iff (!rst_n)
    (wr && paddr == `TRG_ALS_TAIL) |=> s_q.tail == $past(pwdata[15:0]);
  endproperty
  a_alias: assert property (p_alias) else $error("alias miss"); // [R18]

  property p_err;
    @(posedge core_clk) disable iff (!rst_n)
    (psel && penable && paddr == `TRG_OFF_ARB) |-> !pslverr;
  endproperty
  a_err: assert property (p_err) else $error("bad error");

  property p_b2b_gap; // [R1]
    @(posedge core_clk) disable iff (!rst_n)
    (s_q.st == trg_pkg::ST_PHASE1 && s_q.b2b && !frame_done &&
     s_q.cnt + 16'h0001 < b2b_len) |=> s_q.st == trg_pkg::ST_PHASE1;
  endproperty
  a_b2b_gap: assert property (p_b2b_gap) else $error("b2b gap short"); // [R1]

  property p_thr; // [R7]
    @(posedge core_clk) disable iff (!rst_n)
    (s_q.st == trg_pkg::ST_PHASE1 && s_q.b2b && !frame_done &&
     s_q.cnt + 16'h0001 < thr_len) |=> s_q.st == trg_pkg::ST_PHASE1;
  endproperty
  a_thr: assert property (p_thr) else $error("throttle short"); // [R7]

  property p_retry; // [R8]
    @(posedge core_clk) disable iff (!rst_n)
    (s_q.st == trg_pkg::ST_PHASE1 && s_q.b2b && s_q.retry && !frame_done &&
     s_q.cnt + 16'h0001 >= b2b_len) |=> s_q.st == trg_pkg::ST_READY;
  endproperty
  a_retry: assert property (p_retry) else $error("retry throttled"); // [R8]

  property p_fd; // [R8]
    @(posedge core_clk) disable iff (!rst_n)
    frame_done |=> (s_q.st == trg_pkg::ST_PHASE1 && s_q.cnt == 16'h0000 &&
                    s_q.retry == $past(frame_retry));
  endproperty
  a_fd: assert property (p_fd) else $error("gap start"); // [R8]

  property p_full; // [R5]
    @(posedge core_clk) disable iff (!rst_n)
    (s_q.st == trg_pkg::ST_PHASE1 && !s_q.b2b && full_dup && !frame_done &&
     s_q.cnt + 16'h0001 >= b2b_len) |=> s_q.st == trg_pkg::ST_READY;
  endproperty
  a_full: assert property (p_full) else $error("full duplex gap"); // [R5]

  property p_ph1; // [R2]
    @(posedge core_clk) disable iff (!rst_n)
    (s_q.st == trg_pkg::ST_PHASE1 && !s_q.b2b && !full_dup && !s_q.cs_s2 &&
     !frame_done && s_q.cnt + 16'h0001 >= ph1_len) |=>
      s_q.st == trg_pkg::ST_PHASE2;
  endproperty
  a_ph1: assert property (p_ph1) else $error("phase one end"); // [R2]

  property p_ph2_cs; // [R3]
    @(posedge core_clk) disable iff (!rst_n)
    (s_q.st == trg_pkg::ST_PHASE2 && !frame_done) |=>
      s_q.cnt == $past(s_q.cnt) + 16'h0001;
  endproperty
  a_ph2_cs: assert property (p_ph2_cs) else $error("count reset"); // [R3]

  property p_tot; // [R4]
    @(posedge core_clk) disable iff (!rst_n)
    (s_q.st == trg_pkg::ST_PHASE2 && !frame_done &&
     s_q.cnt + 16'h0001 < tot_len) |=> s_q.st == trg_pkg::ST_PHASE2;
  endproperty
  a_tot: assert property (p_tot) else $error("total gap short"); // [R4]

  property p_step; // [R15]
    @(posedge core_clk) disable iff (!rst_n)
    (desc_valid && desc_taken && s_q.head < last_idx) |=>
      s_q.head == $past(s_q.head) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("head step"); // [R15]

  property p_wrap; // [R21]
    @(posedge core_clk) disable iff (!rst_n)
    (desc_valid && desc_taken && s_q.head >= last_idx) |=>
      s_q.head == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("head wrap"); // [R21]

  property p_still; // [R15]
    @(posedge core_clk) disable iff (!rst_n)
    (!(desc_valid && desc_taken) && !wr) |=> $stable(s_q.head);
  endproperty
  a_still: assert property (p_still) else $error("head moved"); // [R15]

  property p_blo_wr; // [R10]
    @(posedge core_clk) disable iff (!rst_n)
    (wr && (paddr == `TRG_OFF_BLO || paddr == `TRG_ALS_BLO)) |=>
      s_q.blo == {$past(pwdata[31:4]), 4'h0};
  endproperty
  a_blo_wr: assert property (p_blo_wr) else $error("base write"); // [R10]

  property p_len_wr; // [R13]
    @(posedge core_clk) disable iff (!rst_n)
    (wr && (paddr == `TRG_OFF_LEN || paddr == `TRG_ALS_LEN)) |=>
      s_q.len == {12'h000, $past(pwdata[19:7]), 7'h00};
  endproperty
  a_len_wr: assert property (p_len_wr) else $error("length write"); // [R13]

  property p_rdata; // [R18]
    @(posedge core_clk) disable iff (!rst_n)
    (rd && paddr == `TRG_ALS_HEAD) |=> prdata == {16'h0000, $past(s_q.head)};
  endproperty
  a_rdata: assert property (p_rdata) else $error("alias read"); // [R18]

  property p_unmapped;
    @(posedge core_clk) disable iff (!rst_n)
    (rd && !hit) |=> prdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule : trg_tx_ring_gap

// ### sim/trg_tx_partner.sv
// Transmit path model: takes descriptors and acknowledges starts
`timescale 1ns/1ps
module trg_tx_partner (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hold,
  input wire logic desc_valid,
  input wire logic tx_start,
  output logic desc_taken,
  output logic tx_ack,
  output logic [15:0] taken_count
);
  // Take every offered descriptor while hold is low
  // Single pulses with a gap, so a stale offer is never taken
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      desc_taken <= 1'b0;
      tx_ack <= 1'b0;
      taken_count <= 16'h0000;
    end else begin
      desc_taken <= desc_valid && !hold && !desc_taken;
      tx_ack <= tx_start && !hold && !tx_ack;
      taken_count <= taken_count + {15'h0000, desc_taken};
    end
  end
endmodule : trg_tx_partner

// ### sim/tx_ring_and_gap_control_test.sv
// Bench for the transmit ring and gap control block
`timescale 1ns/1ps
`include "trg_params.svh"
module tx_ring_and_gap_control_test;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [19:0] paddr = 20'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic carrier_sense = 1'b0;
  logic frame_done = 1'b0;
  logic frame_retry = 1'b0;
  logic hold = 1'b1;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, desc_valid, desc_taken, tx_start, tx_ack;
  logic [63:0] desc_addr;
  logic [15:0] taken;
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;
  int a, b, c, d;
  trg_tx_ring_gap u_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .carrier_sense(carrier_sense), .frame_done(frame_done),
    .frame_retry(frame_retry), .desc_valid(desc_valid),
    .desc_addr(desc_addr), .desc_taken(desc_taken), .tx_start(tx_start),
    .tx_ack(tx_ack));
  trg_tx_partner u_far (.core_clk(core_clk), .rst_n(rst_n), .hold(hold),
    .desc_valid(desc_valid), .tx_start(tx_start), .desc_taken(desc_taken),
    .tx_ack(tx_ack), .taken_count(taken));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [19:0] ad,
    input logic [31:0] dt);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= dt;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [19:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    check(rd, exp);
  endtask : rchk
  task automatic wait_taken(input logic [15:0] n);
    for (int k = 0; k < 200 && taken !== n; k++) @(posedge core_clk);
    check(taken, n);
  endtask : wait_taken
  function automatic logic [31:0] tx_gap_timing(input int t, input int p, int g);
    return 32'(t * 1048576 + p * 1024 + g);
  endfunction : tx_gap_timing
  // Gap length from frame_done to tx_start, in clock cycles
  task automatic gap(input logic [31:0] g, input int t, input logic bb,
    input logic retry, input int cs, output int n);
    apb(1'b1, `TRG_OFF_GAP, g);
    apb(1'b1, `TRG_OFF_THR, 32'(t));
    apb(1'b1, `TRG_OFF_TAIL, bb ? 32'h2 : 32'h1);
    @(posedge core_clk);
    frame_done <= 1'b1;
    frame_retry <= retry;
    @(posedge core_clk);
    frame_done <= 1'b0;
    frame_retry <= 1'b0;
    n = 0;
    // Sample mid-cycle, where the start flag has settled
    do begin
      @(posedge core_clk);
      n++;
      carrier_sense <= cs > 0 && (n == cs || n == cs + 1);
      @(negedge core_clk);
    end while (tx_start !== 1'b1 && n < 400);
    @(posedge core_clk);
    carrier_sense <= 1'b0;
  endtask : gap
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    rchk(`TRG_OFF_STAT, 32'h0000000b);
    rchk(`TRG_OFF_CTRL, 32'h00000000);
    rchk(`TRG_OFF_GAP, 32'h00602008);
    rchk(`TRG_OFF_THR, 32'h00000000);
    rchk(`TRG_OFF_ARB, 32'h00000403);
    apb(1'b1, `TRG_OFF_ARB, 32'h00000405);
    rchk(`TRG_OFF_ARB, 32'h00000405);
    apb(1'b1, `TRG_ALS_BLO, 32'hffffffff);
    rchk(`TRG_OFF_BLO, 32'hfffffff0);
    apb(1'b1, `TRG_OFF_BHI, 32'h000000ab);
    rchk(`TRG_ALS_BHI, 32'h000000ab);
    apb(1'b1, `TRG_OFF_LEN, 32'hffffffff);
    rchk(`TRG_ALS_LEN, 32'h000fff80);
    apb(1'b1, `TRG_ALS_TAIL, 32'hffffffff);
    rchk(`TRG_OFF_TAIL, 32'h0000ffff);
    apb(1'b1, `TRG_ALS_HEAD, 32'h00000005);
    rchk(`TRG_OFF_HEAD, 32'h00000005);
    apb(1'b1, 20'h03900, 32'h00000001);
    check(err, 1'b1);
    rchk(20'h03900, 32'h00000000);
  endtask : t_regs
  task automatic t_ring;
    apb(1'b1, `TRG_OFF_BLO, 32'h10000100);
    apb(1'b1, `TRG_OFF_LEN, 32'h00000080);
    apb(1'b1, `TRG_OFF_TAIL, 32'h00000005);
    apb(1'b1, `TRG_OFF_CTRL, 32'h00000003);
    apb(1'b1, `TRG_OFF_TAIL, 32'h00000007);
    check(desc_addr, 64'h000000ab10000150);
    hold <= 1'b0;
    wait_taken(16'h0002);
    rchk(`TRG_OFF_HEAD, 32'h00000007);
    apb(1'b1, `TRG_OFF_TAIL, 32'h00000001);
    wait_taken(16'h0004);
    rchk(`TRG_OFF_HEAD, 32'h00000001);
    rchk(`TRG_ALS_HEAD, 32'h00000001);
    check(desc_valid, 1'b0);
  endtask : t_ring
  task automatic t_gap;
    hold <= 1'b1;
    gap(tx_gap_timing(0, 0, 10), 0, 1'b1, 1'b0, 0, a);
    check(a, 16);
    gap(tx_gap_timing(0, 0, 20), 0, 1'b1, 1'b0, 0, b);
    check(b - a, 10);
    gap(tx_gap_timing(0, 0, 34), 0, 1'b1, 1'b0, 0, c);
    gap(tx_gap_timing(0, 0, 0), 40, 1'b1, 1'b0, 0, d);
    check(d, c);
    gap(tx_gap_timing(0, 0, 10), 5, 1'b1, 1'b0, 0, c);
    check(c, a);
    gap(tx_gap_timing(0, 0, 10), 40, 1'b1, 1'b1, 0, c);
    check(c, a);
    gap(tx_gap_timing(30, 10, 10), 0, 1'b0, 1'b0, 0, c);
    check(c, a);
    apb(1'b1, `TRG_OFF_CTRL, 32'h00000001);
    gap(tx_gap_timing(20, 10, 0), 0, 1'b0, 1'b0, 0, c);
    check(c, b);
    gap(tx_gap_timing(20, 10, 0), 0, 1'b0, 1'b0, 4, d);
    check(d > c, 1'b1);
    gap(tx_gap_timing(20, 10, 0), 0, 1'b0, 1'b0, 15, d);
    check(d, c);
  endtask : t_gap
  task automatic tally_and_finish;
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_ring();
    t_gap();
    tally_and_finish();
  end
endmodule : tx_ring_and_gap_control_test
